// ### src/adc_pkg.sv
// constants and carrier types of the asynchronous dram cycle controller
package adc_pkg;

  // ---------------------------------------------------------------
  // clock and derived cycle counts
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;

  // least time in ns to whole cycles, rounded up, never below one
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cyc

  // power-up pause and wake-up row strobe cycles
  localparam int POWERUP_US = 200;
  localparam int POWERUP_CYC = min_cyc(POWERUP_US * 1000);
  localparam int INIT_RAS_CYCLES = 8;

  // refresh period over all rows; a longest time rounds down
  localparam int REFRESH_PERIOD_MS = 16;
  localparam int REFRESH_ROWS = 1024;
  localparam int REFRESH_INTERVAL_CYC =
    REFRESH_PERIOD_MS * 1000000 / REFRESH_ROWS / CLK_PERIOD_NS;

  // cycle timing figures in ns
  localparam int ROW_ACCESS_NS = 80;
  localparam int ROW_PRECHARGE_NS = 60;
  localparam int COUNTER_TEST_PRECHARGE_NS = 40;
  localparam int REFRESH_COL_HOLD_NS = 15;
  localparam int ROW_PULSE_NS = 80;
  localparam int CAS_LOW_CYC = min_cyc(ROW_ACCESS_NS);
  localparam int PRE_CYC = (min_cyc(ROW_PRECHARGE_NS) >
    min_cyc(COUNTER_TEST_PRECHARGE_NS)) ? min_cyc(ROW_PRECHARGE_NS)
    : min_cyc(COUNTER_TEST_PRECHARGE_NS);
  localparam int RF_RAS_CYC = (min_cyc(ROW_PULSE_NS) >
    min_cyc(REFRESH_COL_HOLD_NS)) ? min_cyc(ROW_PULSE_NS)
    : min_cyc(REFRESH_COL_HOLD_NS);

  // ---------------------------------------------------------------
  // widths and sized loads
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DQ_W = 4;
  localparam int TMR_W = 12;
  localparam int PH_W = 2;
  localparam int INIT_W = 4;
  localparam logic [TMR_W-1:0] POWERUP_LOAD = TMR_W'(POWERUP_CYC - 1);
  localparam logic [TMR_W-1:0] REFRESH_LOAD =
    TMR_W'(REFRESH_INTERVAL_CYC - 1);
  localparam logic [PH_W-1:0] CAS_LOW_LOAD = PH_W'(CAS_LOW_CYC - 1);
  localparam logic [PH_W-1:0] PRE_LOAD = PH_W'(PRE_CYC - 1);
  localparam logic [PH_W-1:0] RF_RAS_LOAD = PH_W'(RF_RAS_CYC - 1);
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_RAS_CYCLES - 1);

  // ---------------------------------------------------------------
  // carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [DQ_W-1:0] data;
  } adc_req_type;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
  } adc_pins_type;

  localparam adc_pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1,
    {ADDR_W{1'b0}}, {DQ_W{1'b0}}, 1'b0};

  typedef enum logic [8:0] {
    ST_POWERUP = 9'h001,
    ST_IDLE    = 9'h002,
    ST_ROW     = 9'h004,
    ST_RAS     = 9'h008,
    ST_COL     = 9'h010,
    ST_CAS     = 9'h020,
    ST_PRE     = 9'h040,
    ST_RFCAS   = 9'h080,
    ST_RFRAS   = 9'h100
  } adc_state_type;

endpackage : adc_pkg

// ### src/adc_timer.sv
// reloadable down-counting interval timer
`timescale 1ns/10ps
`default_nettype none
module adc_timer #(
  parameter int W = 12,
  parameter logic [W-1:0] START = '0
) (
  input wire logic i_clk,       // system clock
  input wire logic i_rst_n,     // async reset, active low
  input wire logic i_reload,    // restart from START
  output logic o_expired        // count has reached zero
);
  logic [W-1:0] count;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // holds at zero until reloaded, so expiry stays visible as a level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= START;
    end else if (i_reload) begin
      count <= START;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign o_expired = (count == '0);
endmodule : adc_timer
`default_nettype wire

// ### src/adc_ctrl.sv
// host-side cycle controller for an asynchronous page-mode 1Mx4 dram
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl
  import adc_pkg::*;
(
  input wire logic I_REF_CLK,               // 20 MHz system clock
  input wire logic I_RESET_N,               // async reset, active low
  input wire logic I_REQ_VALID,             // access request present
  input wire adc_req_type I_REQ,            // access request contents
  output logic O_REQ_READY,                 // request taken when valid
  output logic O_RD_VALID,                  // read data pulse
  output logic [DQ_W-1:0] O_RD_DATA,        // read data
  output logic O_INIT_DONE,                 // wake-up sequence finished
  output logic O_RAS_N,                     // row strobe pin
  output logic O_CAS_N,                     // column strobe pin
  output logic O_WE_N,                      // write input pin
  output logic O_OE_N,                      // output enable pin
  output logic [ADDR_W-1:0] O_ADDR,         // multiplexed address
  output logic [DQ_W-1:0] O_DQ_OUT,         // data pin drive value
  output logic O_DQ_OE,                     // data pin drive enable
  input wire logic [DQ_W-1:0] I_DQ_IN       // data pin level
);
  adc_state_type state;
  adc_state_type next_state;
  adc_pins_type pins;
  adc_pins_type next_pins;
  adc_req_type cur;
  logic [PH_W-1:0] ph;
  logic [PH_W-1:0] next_ph;
  logic [INIT_W-1:0] init_cnt;
  logic init_done;
  logic rf_pend;
  logic ready;
  logic rd_valid;
  logic [DQ_W-1:0] rd_data;
  logic pwr_expired;
  logic rf_expired;

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  // power-up pause, runs once from reset
  adc_timer #(.W(TMR_W), .START(POWERUP_LOAD)) u_pwr_timer (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RESET_N),
    .i_reload(1'b0),
    .o_expired(pwr_expired)
  );

  // one refresh request per row interval
  adc_timer #(.W(TMR_W), .START(REFRESH_LOAD)) u_rf_timer (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RESET_N),
    .i_reload(rf_expired),
    .o_expired(rf_expired)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire take = (state == ST_IDLE) && I_REQ_VALID && ready;
  wire ph_zero = (ph == '0);
  wire rf_start = (state == ST_IDLE) && (next_state == ST_RFCAS);
  wire rf_end = (state == ST_RFRAS) && ph_zero;
  // only a plain read cycle is ever sampled
  wire rd_sample = (state == ST_CAS) && ph_zero && !cur.write;

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  // pins are computed here and registered, so no pin glitches
  always_comb begin
    next_state = state;
    next_pins = pins;
    next_ph = ph_zero ? ph : ph - PH_W'(1);
    case (state)
      ST_POWERUP: begin
        if (pwr_expired) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!init_done || (rf_pend && !take)) begin
          // column strobe leads the row strobe by one cycle
          next_state = ST_RFCAS;
          next_pins.cas_n = 1'b0;
          // write input kept high, which also avoids test entry
          next_pins.we_n = 1'b1;
        end else if (take) begin
          // row address set up a full cycle before the strobe
          next_state = ST_ROW;
          next_pins.addr = I_REQ.row;
        end
      end
      ST_ROW: begin
        next_state = ST_RAS;
        next_pins.ras_n = 1'b0;
      end
      ST_RAS: begin
        // column address after the row hold time
        next_state = ST_COL;
        next_pins.addr = cur.col;
        if (cur.write) begin
          // write input falls before column strobe, early write
          next_pins.we_n = 1'b0;
          // data valid ahead of the column strobe fall
          // pins released by the device well before this drive
          next_pins.dq_out = cur.data;
          next_pins.dq_oe = 1'b1;
        end
      end
      ST_COL: begin
        next_state = ST_CAS;
        next_pins.cas_n = 1'b0;
        next_pins.oe_n = cur.write;
        next_ph = CAS_LOW_LOAD;
      end
      ST_CAS: begin
        // strobe low long enough that any access path has settled
        // write input already low for three cycles at this rise
        // a read leaves the write input high past this rise
        if (ph_zero) begin
          next_state = ST_PRE;
          next_pins.ras_n = 1'b1;
          next_pins.cas_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_ph = PRE_LOAD;
        end
      end
      ST_PRE: begin
        // data and write input released only after the strobes
        next_pins.we_n = 1'b1;
        next_pins.dq_oe = 1'b0;
        // column strobe stays high for the full precharge
        if (ph_zero) begin
          next_state = ST_IDLE;
        end
      end
      ST_RFCAS: begin
        next_state = ST_RFRAS;
        next_pins.ras_n = 1'b0;
        next_ph = RF_RAS_LOAD;
      end
      ST_RFRAS: begin
        // column strobe held low past the row strobe fall
        if (ph_zero) begin
          next_state = ST_PRE;
          next_pins.ras_n = 1'b1;
          next_pins.cas_n = 1'b1;
          next_ph = PRE_LOAD;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_pins = PINS_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // ready is withheld from the cycle after refresh becomes owed, so refresh cannot starve
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= ST_POWERUP;
      pins <= PINS_IDLE;
      ph <= '0;
      ready <= 1'b0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      ph <= next_ph;
      ready <= (next_state == ST_IDLE) && init_done && !rf_pend;
    end
  end

  // request capture and read data
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cur <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      if (take) begin
        cur <= I_REQ;
      end
      rd_valid <= rd_sample;
      // sampled while column strobe and enable are still low
      if (rd_sample) begin
        rd_data <= I_DQ_IN;
      end
    end
  end

  // eight row strobe cycles counted; set wins over clear
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      init_cnt <= '0;
      init_done <= 1'b0;
      rf_pend <= 1'b0;
    end else begin
      rf_pend <= rf_expired | (rf_pend & !rf_start);
      if (rf_end && !init_done) begin
        init_cnt <= init_cnt + INIT_W'(1);
        init_done <= (init_cnt == INIT_LAST);
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign O_REQ_READY = ready;
  assign O_RD_VALID = rd_valid;
  assign O_RD_DATA = rd_data;
  assign O_INIT_DONE = init_done;
  assign O_RAS_N = pins.ras_n;
  assign O_CAS_N = pins.cas_n;
  assign O_WE_N = pins.we_n;
  assign O_OE_N = pins.oe_n;
  assign O_ADDR = pins.addr;
  assign O_DQ_OUT = pins.dq_out;
  assign O_DQ_OE = pins.dq_oe;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);

  a_powerup_wait: assert property (
    $fell(pins.ras_n) |-> pwr_expired) else $error("ras before pause");
  a_init_count: assert property (
    $rose(init_done) |-> $past(init_cnt) == INIT_LAST && $past(rf_end))
    else $error("init done without eight cycles");
  a_read_hold: assert property (
    (!pins.cas_n && pins.we_n && !pins.ras_n) ##1 pins.cas_n
    |-> pins.we_n) else $error("write fell at read end");
  a_early_write: assert property (
    $fell(pins.cas_n) && !pins.ras_n && !pins.we_n
    |-> $past(!pins.we_n) && $past(pins.dq_oe) && pins.oe_n)
    else $error("write not early");
  a_write_lead: assert property (
    $rose(pins.cas_n) && $past(!pins.we_n) |-> $past(!pins.we_n, 3))
    else $error("write lead too short");
  a_data_hold: assert property (
    pins.dq_oe && !pins.cas_n |=> $stable(pins.dq_out) && pins.dq_oe)
    else $error("write data moved");
  a_refresh_order: assert property (
    $fell(pins.ras_n) && !pins.cas_n
    |-> $past(!pins.cas_n) && pins.we_n ##1 !pins.cas_n && pins.we_n)
    else $error("refresh strobe order");
  a_cas_precharge: assert property (
    $rose(pins.cas_n) |-> pins.cas_n [*2])
    else $error("column precharge short");
  a_addr_mux: assert property (
    $fell(pins.cas_n) && !pins.ras_n |-> pins.addr == cur.col)
    else $error("column address wrong");
  a_refresh_due: assert property (
    $rose(rf_pend) && init_done |-> ##[1:20] (state == ST_RFCAS))
    else $error("refresh not served");
  a_read_sample: assert property (
    rd_valid |-> $past(!pins.cas_n && !pins.oe_n && pins.we_n))
    else $error("sampled outside read");

  c_read: cover property (rd_valid);
  c_write: cover property ($fell(pins.cas_n) && !pins.we_n);
  c_refresh: cover property (state == ST_RFRAS && init_done);
  c_init: cover property ($rose(init_done));
endmodule : adc_ctrl
`default_nettype wire

// ### bench/adc_dram_model.sv
// behavioural 1m x 4 dram that faces the controller pins
`timescale 1ns/10ps
`default_nettype none
module adc_dram_model
  import adc_pkg::*;
(
  input wire logic i_ras_n,              // row strobe
  input wire logic i_cas_n,              // column strobe
  input wire logic i_we_n,               // write input
  input wire logic i_oe_n,               // output enable
  input wire logic [ADDR_W-1:0] i_addr,  // multiplexed address
  input wire logic [DQ_W-1:0] i_dq,      // data pin level
  output logic [DQ_W-1:0] o_q,           // read data drive value
  output logic o_q_oe,                   // high while driving
  output var int o_ras_count,            // row strobe cycles seen
  output var int o_refresh_count,        // refresh cycles seen
  output var int o_viol                  // controller timing faults
);
  // ---------------------------------------------------------
  // storage and pin history
  // ---------------------------------------------------------
  logic [DQ_W-1:0] mem [logic [19:0]];
  logic [ADDR_W-1:0] row;
  logic refresh = 1'b0;
  logic rd_cyc = 1'b0;
  logic wr_cyc = 1'b0;
  logic q_ready = 1'b0;
  realtime t_rf = 0.0;
  realtime t_cf = 0.0;
  realtime t_wf = 0.0;
  realtime t_wr = 0.0;
  initial begin
    o_ras_count = 0;
    o_refresh_count = 0;
    o_viol = 0;
    o_q = '0;
  end
  // drive only while strobe and enable low, release at once
  assign o_q_oe = !i_cas_n && !i_oe_n && i_we_n && rd_cyc && q_ready;
  always @(negedge i_we_n) begin
    t_wf = $realtime;
    // write falling under low strobes would be late or read-write
    if (!i_cas_n && !i_ras_n) o_viol++;
    // write input held high after refresh row fall
    if (refresh && $realtime - t_rf < 10.0) o_viol++;
  end
  always @(posedge i_we_n) t_wr = $realtime;
  // row address latched by the falling row strobe
  always @(negedge i_ras_n) begin
    t_rf = $realtime;
    row = i_addr;
    o_ras_count++;
    refresh = !i_cas_n;
    wr_cyc = 1'b0;
    if (refresh) begin
      o_refresh_count++;
      // column strobe leads the row strobe
      if (t_rf - t_cf < 5.0) o_viol++;
      // write input high before refresh row fall
      if (!i_we_n || t_rf - t_wr < 10.0) o_viol++;
    end
  end
  // early write captures at column fall, outputs stay off
  always @(negedge i_cas_n) begin
    t_cf = $realtime;
    q_ready = 1'b0;
    if (!i_ras_n) begin
      // pause and eight row cycles before any access
      if ($realtime < 200000.0 || o_ras_count < 8) o_viol++;
      wr_cyc = !i_we_n;
      rd_cyc = i_we_n;
      if (!i_we_n) mem[{row, i_addr}] = i_dq;
      else o_q = mem.exists({row, i_addr}) ? mem[{row, i_addr}] : '0;
      // access time counted from the column strobe
      q_ready <= #20 1'b1;
    end
  end
  always @(posedge i_cas_n) begin
    // read ends with write input still high
    if (rd_cyc && !i_we_n) o_viol++;
    // column strobe held low after refresh row fall
    if (refresh && $realtime - t_rf < 15.0) o_viol++;
    // write input leads the rising column strobe
    if (wr_cyc && $realtime - t_wf < 20.0) o_viol++;
    rd_cyc = 1'b0;
  end
  always @(posedge i_ras_n) begin
    // write input leads the rising row strobe
    if (wr_cyc && $realtime - t_wf < 20.0) o_viol++;
    refresh = 1'b0;
  end
  // write data held after the column and row falls
  always @(i_dq) begin
    if (wr_cyc && ($realtime - t_cf < 15.0 || $realtime - t_rf < 60.0))
      o_viol++;
  end
endmodule : adc_dram_model
`default_nettype wire

// ### bench/adc_ctrl_tb.sv
// self-checking bench for the dram cycle controller
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_tb;
  import adc_pkg::*;
  // ---------------------------------------------------------
  // signals, design and partner
  // ---------------------------------------------------------
  logic clk, rst_n, req_valid, req_ready, rd_valid, init_done;
  logic ras_n, cas_n, we_n, oe_n, dq_oe, mdl_oe;
  adc_req_type req;
  logic [DQ_W-1:0] rd_data, dq_out, dq_level, last_dq, mdl_q;
  logic [ADDR_W-1:0] addr;
  logic [31:0] seed;
  logic [DQ_W-1:0] ref_mem [logic [19:0]];
  logic [19:0] used [$];
  int ras_count, refresh_count, viol, fail_count, total_checks, cyc;
  adc_ctrl DUT (.I_REF_CLK(clk), .I_RESET_N(rst_n),
    .I_REQ_VALID(req_valid), .I_REQ(req), .O_REQ_READY(req_ready),
    .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_INIT_DONE(init_done),
    .O_RAS_N(ras_n), .O_CAS_N(cas_n), .O_WE_N(we_n), .O_OE_N(oe_n),
    .O_ADDR(addr), .O_DQ_OUT(dq_out), .O_DQ_OE(dq_oe),
    .I_DQ_IN(dq_level));
  adc_dram_model MDL (.i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .i_addr(addr), .i_dq(dq_level), .o_q(mdl_q),
    .o_q_oe(mdl_oe), .o_ras_count(ras_count),
    .o_refresh_count(refresh_count), .o_viol(viol));
  // undriven data pins show the inverse of the last driven level
  assign dq_level = dq_oe ? dq_out : (mdl_oe ? mdl_q : ~last_dq);
  always @(dq_level) if (dq_oe || mdl_oe) last_dq = dq_level;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : next_rand
  function automatic logic [DQ_W-1:0] exp_data(input logic [19:0] a);
    return ref_mem[a];
  endfunction : exp_data
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : report
  task automatic check_data(input logic [DQ_W-1:0] g, logic [DQ_W-1:0] e);
    report(32'(g), 32'(e));
  endtask : check_data
  task automatic check_num(input logic [31:0] g, input logic [31:0] e);
    report(g, e);
  endtask : check_num
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // one request, entered and left at a falling edge
  task automatic access(input logic wr, logic [19:0] a, logic [3:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        fail_count++;
        stop_test();
      end
    end
    req_valid = 1'b1;
    req = '{wr, a[19:10], a[9:0], d};
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    req = ~req;
    if (wr) begin
      ref_mem[a] = d;
      used.push_back(a);
    end else begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      check_num(32'(n), 32'(3 + CAS_LOW_CYC));
      check_data(rd_data, exp_data(a));
    end
  endtask : access
  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    int n, r0, c0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    last_dq = '0;
    cyc = 0;
    seed = 32'd61836;
    fail_count = 0;
    total_checks = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    c0 = cyc;
    n = 0;
    while (init_done !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    // a wake-up that never ends is a failure, not a hang
    if (n >= 6000) begin
      fail_count++;
      stop_test();
    end
    check_num(32'(cyc - c0 >= POWERUP_CYC), 32'd1);
    check_num(32'(ras_count >= INIT_RAS_CYCLES), 32'd1);
    r0 = refresh_count;
    c0 = cyc;
    // corners: end addresses, back to back
    access(1'b1, 20'h00000, 4'hf);
    access(1'b1, 20'hfffff, 4'h0);
    access(1'b1, 20'hffc00, 4'ha);
    access(1'b0, 20'h00000, 4'h5);
    access(1'b0, 20'hfffff, 4'h5);
    access(1'b0, 20'hffc00, 4'h5);
    repeat (200) begin
      seed = next_rand(seed);
      if (seed[0]) access(1'b1, seed[31:12], seed[7:4]);
      else access(1'b0, used[seed[15:4] % used.size()], seed[7:4]);
    end
    repeat (1500) @(negedge clk);
    n = (cyc - c0) / REFRESH_INTERVAL_CYC;
    c0 = refresh_count - r0;
    check_num(32'(c0 >= n - 1 && c0 <= n + 1), 32'd1);
    check_num(32'(viol), 32'd0);
    stop_test();
  end
endmodule : adc_ctrl_tb
`default_nettype wire
